// file: rtl/tbg_access_guard.v
// Block memory access guard: identification record, password and user
// configuration blocks, with write protection of the identification area.
// Assumes the command decoder presents one block request per pulse and a
// separate unit asserts the password-verified level after authentication.
`timescale 1ns/1ps
`default_nettype none
`include "tbg_defs.vh"
module tbg_access_guard #(
	parameter ID_BLOCKS = `TBG_MEM_DEPTH
) (
	// Clock and reset
	input wire i_mclk,
	input wire i_sys_rst,
	// Block request from the command decoder
	input wire i_req,
	input wire i_wr,
	input wire [`TBG_ADDR_W-1:0] i_addr,
	input wire [`TBG_BLOCK_W-1:0] i_wdata,
	// Authentication and lock state
	input wire i_pwd_ok,
	input wire i_lock_cfg,
	input wire i_lock_pwd,
	// Answer
	output reg o_done,
	output reg o_ok,
	output reg o_denied,
	output reg [`TBG_BLOCK_W-1:0] o_rdata,
	// Configuration state
	output reg [`TBG_BLOCK_W-1:0] o_cfg,
	output reg o_id_area_write_guard
);
	localparam ST_IDLE = 1'b0;
	localparam ST_READ = 1'b1;

	localparam TOTAL_BITS = (ID_BLOCKS + 2) * `TBG_BLOCK_W;

	function is_id_block;
		input [`TBG_ADDR_W-1:0] a;
		begin
			is_id_block = (a >= `TBG_ID_FIRST) && (a <= `TBG_ID_LAST);
		end
	endfunction

	reg state_q;
	reg cfg_locked_q;
	reg pwd_locked_q;
	reg [`TBG_BLOCK_W-1:0] pwd_q;
	reg [`TBG_BLOCK_W-1:0] cfg_q;
	reg lock_seen_q;
	wire [`TBG_BLOCK_W-1:0] mem_rdata;
	wire id_hit;
	wire guard_on;
	wire id_wr_ok;
	wire mem_we;
	wire mem_re;

	assign id_hit = is_id_block(i_addr);
	assign guard_on = cfg_q[`TBG_CFG_ID_GUARD_BIT];
	assign id_wr_ok = !guard_on || i_pwd_ok;
	assign mem_we = (state_q == ST_IDLE) && i_req && i_wr && id_hit &&
		id_wr_ok;
	assign mem_re = (state_q == ST_IDLE) && i_req && !i_wr && id_hit;

	tbg_block_mem #(
		.DEPTH(`TBG_MEM_DEPTH),
		.AW(`TBG_MEM_AW),
		.DW(`TBG_BLOCK_W)
	) u_mem (
		.i_mclk(i_mclk),
		.i_we(mem_we),
		.i_waddr(i_addr[`TBG_MEM_AW-1:0]),
		.i_wdata(i_wdata),
		.i_re(mem_re),
		.i_raddr(i_addr[`TBG_MEM_AW-1:0]),
		.o_rdata(mem_rdata)
	);

	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
			cfg_q <= `TBG_CFG_RESET;
			pwd_q <= `TBG_PASSWORD_RESET;
			cfg_locked_q <= 1'b0;
			pwd_locked_q <= 1'b0;
			lock_seen_q <= 1'b0;
			o_done <= 1'b0;
			o_ok <= 1'b0;
			o_denied <= 1'b0;
			o_rdata <= {`TBG_BLOCK_W{1'b0}};
			o_cfg <= `TBG_CFG_RESET;
			o_id_area_write_guard <= 1'b0;
		end else begin
			o_done <= 1'b0;
			o_ok <= 1'b0;
			o_denied <= 1'b0;
			lock_seen_q <= 1'b1;
			if (i_lock_cfg && lock_seen_q) begin
				cfg_locked_q <= 1'b1;
			end
			if (i_lock_pwd && lock_seen_q) begin
				pwd_locked_q <= 1'b1;
			end
			o_cfg <= cfg_q;
			o_id_area_write_guard <= guard_on;
			case (state_q)
				ST_IDLE: begin
					if (i_req && !i_wr && id_hit) begin
						state_q <= ST_READ;
					end else if (i_req) begin
						o_done <= 1'b1;
						if (id_hit) begin
							o_ok <= id_wr_ok;
							o_denied <= !id_wr_ok;
						end else if (i_addr == `TBG_ADDR_USER_CFG) begin
							if (!i_wr) begin
								o_rdata <= cfg_q;
								o_ok <= 1'b1;
							end else if (cfg_locked_q) begin
								o_denied <= 1'b1;
							end else begin
								cfg_q <= i_wdata & `TBG_CFG_USED_MASK;
								o_ok <= 1'b1;
							end
						end else if (i_addr == `TBG_ADDR_PASSWORD) begin
							if (!i_wr) begin
								o_rdata <= pwd_q;
								o_ok <= 1'b1;
							end else if (pwd_locked_q) begin
								o_denied <= 1'b1;
							end else begin
								pwd_q <= i_wdata;
								o_ok <= 1'b1;
							end
						end else begin
							o_denied <= 1'b1;
						end
					end
				end
				ST_READ: begin
					o_rdata <= mem_rdata;
					o_ok <= 1'b1;
					o_done <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: rtl/tbg_defs.vh
// Constants for the transponder block memory access guard.
// Assumes a single 200 MHz clock and block-granular access only.
`ifndef TBG_DEFS_VH
`define TBG_DEFS_VH
`define TBG_BLOCK_W 32
`define TBG_ADDR_W 8
`define TBG_MAX_BITS 1760
`define TBG_ID_FIRST 8'h00
`define TBG_ID_LAST 8'h03
`define TBG_ADDR_PASSWORD 8'hFE
`define TBG_ADDR_USER_CFG 8'hFF
`define TBG_CFG_ID_GUARD_BIT 3
`define TBG_CFG_GUARD_LO 3
`define TBG_CFG_GUARD_HI 6
`define TBG_CFG_RESET 32'h0000_0001
`define TBG_PASSWORD_RESET 32'h0000_0000
`define TBG_CFG_USED_MASK 32'h0000_007F
`define TBG_MEM_DEPTH 4
`define TBG_MEM_AW 2
`endif

// file: rtl/tbg_block_mem.v
// Small word memory for the identification record blocks.
// Assumes one write or one read per cycle; read data are registered.
`timescale 1ns/1ps
`default_nettype none
module tbg_block_mem #(
	parameter DEPTH = 4,
	parameter AW = 2,
	parameter DW = 32
) (
	// Clock
	input wire i_mclk,
	// Write port
	input wire i_we,
	input wire [AW-1:0] i_waddr,
	input wire [DW-1:0] i_wdata,
	// Read port
	input wire i_re,
	input wire [AW-1:0] i_raddr,
	output reg [DW-1:0] o_rdata
);
	reg [DW-1:0] mem [0:DEPTH-1];
	always @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_re) begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule
`default_nettype wire

// file: testbench/tbg_access_guard_props.sv
// Port checks for the access guard.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module tbg_guard_chk (
	input wire logic i_mclk, i_sys_rst, i_req, i_wr, i_pwd_ok,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata, o_cfg,
	input wire logic o_done, o_ok, o_denied, o_id_area_write_guard
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	logic b;
	logic [1:0] h;
	wire t = i_req && !b;
	wire id = t && i_addr < 4;
	wire cw = t && i_wr && i_addr == 8'hFF;
	// An id read keeps the block busy one more cycle, so requests are ignored.
	always_ff @(posedge i_mclk) begin
		b <= !i_sys_rst && i_req && !i_wr && i_addr < 4 && !b;
		h <= {h[0], cw};
	end
	sequence s_cw; cw ##1 o_ok; endsequence
	property p_gd; o_id_area_write_guard == o_cfg[3]; endproperty
	property p_dn; o_done |-> o_ok ^ o_denied; endproperty
	property p_fw; id && i_wr && !o_id_area_write_guard && !h |=> o_ok;
	endproperty
	property p_gw; id && i_wr && o_id_area_write_guard && !i_pwd_ok && !h
		|=> o_denied; endproperty
	property p_pw; id && i_wr && i_pwd_ok |=> o_ok; endproperty
	property p_rd; id && !i_wr |-> ##2 o_done && o_ok; endproperty
	property p_um; t && i_addr inside {[8'h04:8'hFD]} |=> o_denied;
	endproperty
	property p_cd; s_cw |=> o_cfg[6:0] == $past(i_wdata[6:0], 2);
	endproperty
	a_gd: assert property (p_gd) else $error("guard copy");
	a_dn: assert property (p_dn) else $error("answer code");
	a_fw: assert property (p_fw) else $error("open write");
	a_gw: assert property (p_gw) else $error("guarded write");
	a_pw: assert property (p_pw) else $error("password write");
	a_rd: assert property (p_rd) else $error("id read");
	a_um: assert property (p_um) else $error("unmapped");
	a_cd: assert property (p_cd) else $error("config word");
endmodule
bind tbg_access_guard tbg_guard_chk chk_i (.*);
`default_nettype wire

// file: testbench/tbg_reader_writer_unit.sv
// Reader model issuing one block command at a time.
// Assumes an answer within three cycles.
`timescale 1ns/1ps
`default_nettype none
module tbg_reader_writer_unit (
	input wire logic i_mclk,
	input wire logic i_done,
	input wire logic i_ok,
	input wire logic i_denied,
	output logic o_req,
	output logic o_wr,
	output logic [7:0] o_addr,
	output logic [31:0] o_wdata
);
	initial {o_req, o_wr, o_addr, o_wdata} = '0;
	task automatic blk(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [1:0] s);
		int n;
		@(negedge i_mclk);
		{o_req, o_wr, o_addr, o_wdata} = {1'b1, w, a, d};
		@(negedge i_mclk);
		{o_req, o_addr, o_wdata} = {1'b0, ~a, ~d};
		for (n = 0; n < 3 && !i_done; n++)
			@(negedge i_mclk);
		if (!i_done)
			tb_top.results(1);
		s = {i_ok, i_denied};
	endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the access guard.
// Assumes the reader model in its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, rst = 1, pw = 0, lk = 0, req, wr, done, ok, dn, g;
	logic [1:0] s;
	logic [7:0] a;
	logic [31:0] wd, rd, cfg;
	int failures = 0, cmp_count = 0;
	always #2.5 clk = ~clk;
	tbg_access_guard uut (.i_mclk(clk), .i_sys_rst(rst), .i_req(req),
		.i_wr(wr), .i_addr(a), .i_wdata(wd), .i_pwd_ok(pw),
		.i_lock_cfg(lk), .i_lock_pwd(lk), .o_done(done), .o_ok(ok),
		.o_denied(dn), .o_rdata(rd), .o_cfg(cfg),
		.o_id_area_write_guard(g));
	tbg_reader_writer_unit rw (.i_mclk(clk), .i_done(done), .i_ok(ok),
		.i_denied(dn),
		.o_req(req), .o_wr(wr), .o_addr(a), .o_wdata(wd));
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results(input int f);
		failures += f;
		if (failures == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_open;
		chk(cfg, 32'h0000_0001);
		rw.blk(1, 8'h02, 32'hA5C3_0F96, s);
		chk(s, 2'b10);
		rw.blk(0, 8'h02, 0, s);
		chk(rd, 32'hA5C3_0F96);
	endtask
	task automatic t_guard;
		rw.blk(1, 8'hFF, 32'hFFFF_FF89, s);
		rw.blk(1, 8'h02, 32'h1234_5678, s);
		chk(g, 1);
		chk(s, 2'b01);
		rw.blk(0, 8'h02, 0, s);
		chk(rd, 32'hA5C3_0F96);
		pw = 1;
		rw.blk(1, 8'h03, 32'h0F0F_F0F0, s);
		chk(s, 2'b10);
	endtask
	task automatic t_map;
		rw.blk(1, 8'hFE, 32'h3C3C_C3C3, s);
		chk(s, 2'b10);
		rw.blk(0, 8'hFE, 0, s);
		chk(rd, 32'h3C3C_C3C3);
		rw.blk(0, 8'hFF, 0, s);
		chk(rd, 32'h0000_0009);
		rw.blk(1, 8'h04, 0, s);
		chk(s, 2'b01);
		lk = 1;
		@(negedge clk);
		lk = 0;
		rw.blk(1, 8'hFF, 0, s);
		chk(s, 2'b01);
		rw.blk(1, 8'hFE, 0, s);
		chk(s, 2'b01);
		rw.blk(0, 8'hFE, 0, s);
		chk(rd, 32'h3C3C_C3C3);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		t_open;
		t_guard;
		t_map;
		results(0);
	end
endmodule
`default_nettype wire
